/* design/porq_pkg.sv */
// Package with register map, field layout, reset values and timing constants of the reset sequencer.
package porq_pkg;
	// Printed register indices; the APB byte address is four times the index.
	localparam logic [23:0] IDX_CLOCK_RESET_CONTROL  = 24'hfffc40;
	localparam logic [23:0] IDX_FAST_CLOCK_PRESCALER = 24'hfffc42;
	localparam logic [23:0] IDX_SLOW_CLOCK_PRESCALER = 24'hfffc44;
	localparam logic [23:0] IDX_AUX_CLOCK_PRESCALER  = 24'hfffc46;

	// Field positions of clock_reset_control.
	localparam int CRC_SCLK   = 0;
	localparam int CRC_FCLK   = 1;
	localparam int CRC_PLLPWD = 2;
	localparam int CRC_ACE1   = 3;
	localparam int CRC_ACE2   = 4;
	localparam int CRC_POR    = 5;

	// Register reset values and the fast prescaler write mask.
	localparam logic [7:0] CRC_RESET  = 8'h26;
	localparam logic [7:0] FAST_RESET = 8'h40;
	localparam logic [7:0] SLOW_RESET = 8'hb6;
	localparam logic [7:0] AUX_RESET  = 8'hff;
	localparam logic [7:0] FAST_MASK  = 8'h7f;

	// Reset-delay and oscillator start-up counters.
	localparam int          DELAY_WIDTH  = 14;
	localparam logic [13:0] DELAY_PRESET = 14'h3fff;
	localparam logic [13:0] DELAY_ZERO   = 14'h0000;
	localparam int          OSC_STARTUP_CYCLES = 32768;
	localparam int          OSC_TICK_DIV = OSC_STARTUP_CYCLES / (1 << DELAY_WIDTH);
endpackage

/* design/porq_osc_timer.sv */
// Main oscillator start-up timer that raises the good-clock indication.
`timescale 1ns/100ps
module porq_osc_timer #(
	parameter int WIDTH   = porq_pkg::DELAY_WIDTH,
	parameter int TICKDIV = porq_pkg::OSC_TICK_DIV
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Oscillator control and status
	input  wire logic osc_stop,
	output logic      good_clock
);
	logic [WIDTH-1:0] cnt_r;
	logic [7:0]       div_r;
	logic             tick;

	// A 14-bit timer cannot span 32,768 cycles alone, so it steps on a divided enable.
	assign tick = (div_r == 8'(TICKDIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 8'h00;
		end else if (osc_stop || tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= porq_pkg::DELAY_PRESET;
		end else if (osc_stop) begin
			cnt_r <= porq_pkg::DELAY_PRESET;
		end else if (tick && cnt_r != porq_pkg::DELAY_ZERO) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_clock <= 1'b0;
		end else begin
			good_clock <= !osc_stop && cnt_r == porq_pkg::DELAY_ZERO;
		end
	end
endmodule

/* design/porq_sequencer.sv */
// Power-on reset sequencer with clock and reset register map on APB.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module porq_sequencer (
	// Clock and power-on reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External reset pin and clock status
	input  wire logic        ext_reset_n,
	input  wire logic        osc_stop,
	input  wire logic        pll_stable,
	// Internal reset and clock controls
	output logic             core_reset_n,
	output logic             good_main_clock,
	output logic             slow_clock_sel,
	output logic             fast_clock_sel,
	output logic             pll_power_down,
	output logic             aux1_run,
	output logic             aux2_run,
	output logic      [7:0]  fast_clock_prescaler,
	output logic      [7:0]  slow_clock_prescaler,
	output logic      [7:0]  aux_clock_prescaler
);
	logic [13:0] delay_r;
	logic [7:0]  crc_r;
	logic        pin_meta_r;
	logic        pin_sync_r;
	logic        pll_meta_r;
	logic        pll_sync_r;
	logic        good_clock;
	logic        access;
	logic        wr_en;
	logic [1:0]  sel;
	logic        hit;
	logic [7:0]  crc_nxt;
	logic [7:0]  rd_nxt;

	// Returns true when the byte address is the word of the given register index.
	function automatic logic addr_is(input logic [31:0] addr, input logic [23:0] idx);
		return addr == {6'h00, idx, 2'b00};
	endfunction

	porq_osc_timer u_osc_timer (
		.pclk       (pclk),
		.presetn    (presetn),
		.osc_stop   (osc_stop),
		.good_clock (good_clock)
	);

	// Reset pin synchroniser; clears at once so assertion needs no clock edge.
	always_ff @(posedge pclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
		end else begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= pin_meta_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_meta_r <= 1'b0;
			pll_sync_r <= 1'b0;
		end else begin
			pll_meta_r <= pll_stable;
			pll_sync_r <= pll_meta_r;
		end
	end

	// Reset-delay counter runs only from power-up; the pin does not reload it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_r <= porq_pkg::DELAY_PRESET;
		end else if (good_clock && delay_r != porq_pkg::DELAY_ZERO) begin
			delay_r <= delay_r - 1'b1;
		end
	end

	// Internal reset: pin or power-on clears it without a clock; release needs both conditions.
	always_ff @(posedge pclk or negedge presetn or negedge ext_reset_n) begin
		if (!presetn || !ext_reset_n) begin
			core_reset_n <= 1'b0;
		end else begin
			core_reset_n <= delay_r == porq_pkg::DELAY_ZERO && pin_sync_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_main_clock <= 1'b0;
		end else begin
			good_main_clock <= good_clock;
		end
	end

	// APB decode with one wait state so that read data comes from a flip-flop.
	assign access = psel && penable;
	assign wr_en  = access && pready && pwrite && hit;

	always_comb begin
		sel = 2'd0;
		hit = 1'b1;
		if (addr_is(paddr, porq_pkg::IDX_CLOCK_RESET_CONTROL)) begin
			sel = 2'd0;
		end else if (addr_is(paddr, porq_pkg::IDX_FAST_CLOCK_PRESCALER)) begin
			sel = 2'd1;
		end else if (addr_is(paddr, porq_pkg::IDX_SLOW_CLOCK_PRESCALER)) begin
			sel = 2'd2;
		end else if (addr_is(paddr, porq_pkg::IDX_AUX_CLOCK_PRESCALER)) begin
			sel = 2'd3;
		end else begin
			hit = 1'b0;
		end
	end

	always_comb begin
		case (sel)
			2'd0:    rd_nxt = crc_r;
			2'd1:    rd_nxt = fast_clock_prescaler;
			2'd2:    rd_nxt = slow_clock_prescaler;
			2'd3:    rd_nxt = aux_clock_prescaler;
			default: rd_nxt = 8'h00;
		endcase
		if (!hit) begin
			rd_nxt = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !hit;
			prdata  <= (access && !pready && !pwrite) ? {24'h000000, rd_nxt} : 32'h00000000;
		end
	end

	// Clock control write: guarded fast-clock selection and PLL power-down, unguarded slow-clock selection, clear-only power-on flag.
	always_comb begin
		crc_nxt = crc_r;
		crc_nxt[porq_pkg::CRC_SCLK] = pwdata[porq_pkg::CRC_SCLK];
		crc_nxt[porq_pkg::CRC_ACE1] = pwdata[porq_pkg::CRC_ACE1];
		crc_nxt[porq_pkg::CRC_ACE2] = pwdata[porq_pkg::CRC_ACE2];
		if (pwdata[porq_pkg::CRC_FCLK] || (!crc_r[porq_pkg::CRC_PLLPWD] && pll_sync_r)) begin
			crc_nxt[porq_pkg::CRC_FCLK] = pwdata[porq_pkg::CRC_FCLK];
		end
		if (!pwdata[porq_pkg::CRC_PLLPWD] || crc_nxt[porq_pkg::CRC_FCLK]) begin
			crc_nxt[porq_pkg::CRC_PLLPWD] = pwdata[porq_pkg::CRC_PLLPWD];
		end
		if (!pwdata[porq_pkg::CRC_POR]) begin
			crc_nxt[porq_pkg::CRC_POR] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_r <= porq_pkg::CRC_RESET;
		end else if (wr_en && sel == 2'd0) begin
			crc_r <= crc_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_clock_prescaler <= porq_pkg::FAST_RESET;
			slow_clock_prescaler <= porq_pkg::SLOW_RESET;
			aux_clock_prescaler  <= porq_pkg::AUX_RESET;
		end else if (wr_en) begin
			if (sel == 2'd1) begin
				fast_clock_prescaler <= pwdata[7:0] & porq_pkg::FAST_MASK;
			end
			if (sel == 2'd2) begin
				slow_clock_prescaler <= pwdata[7:0];
			end
			if (sel == 2'd3) begin
				aux_clock_prescaler <= pwdata[7:0];
			end
		end
	end

	// Auxiliary clocks only run from a stable main clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_clock_sel <= 1'b0;
			fast_clock_sel <= 1'b1;
			pll_power_down <= 1'b1;
			aux1_run       <= 1'b0;
			aux2_run       <= 1'b0;
		end else begin
			slow_clock_sel <= crc_r[porq_pkg::CRC_SCLK];
			fast_clock_sel <= crc_r[porq_pkg::CRC_FCLK];
			pll_power_down <= crc_r[porq_pkg::CRC_PLLPWD];
			aux1_run       <= crc_r[porq_pkg::CRC_ACE1] && good_clock;
			aux2_run       <= crc_r[porq_pkg::CRC_ACE2] && good_clock;
		end
	end
endmodule

/* tb/porq_seq_properties.sv */
// Checker of reset release and APB timing at the sequencer ports.
`timescale 1ns/100ps
module porq_chk (
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Reset pin and status
	input wire logic        ext_reset_n,
	input wire logic        osc_stop,
	input wire logic        core_reset_n,
	input wire logic        good_main_clock
);
	logic [16:0] run_r;
	logic [16:0] good_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r  <= 17'h0;
			good_r <= 17'h0;
		end else begin
			run_r  <= osc_stop ? 17'h0 : run_r + 17'h1;
			good_r <= good_main_clock ? good_r + 17'h1 : 17'h0;
		end
	end
	property p_async; !ext_reset_n |-> !core_reset_n; endproperty
	a_async: assert property (p_async) else $error("core reset free while pin low");
	property p_sync; $rose(core_reset_n) |-> $past(ext_reset_n, 2); endproperty
	a_sync: assert property (p_sync) else $error("core reset left before pin settled");
	property p_gate; $rose(core_reset_n) |-> good_main_clock && good_r >= 17'd16380; endproperty
	a_gate: assert property (p_gate) else $error("core reset left before delay ran out");
	property p_rel; ext_reset_n [*5] ##0 good_r > 17'd16400 |-> core_reset_n; endproperty
	a_rel: assert property (p_rel) else $error("core reset not left after delay");
	property p_osc; $rose(good_main_clock) |-> run_r > 17'd32763 && run_r < 17'd32777; endproperty
	a_osc: assert property (p_osc) else $error("good clock at wrong time");
	property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("bus answer not after one wait");
	property p_err; pready |-> pslverr == (paddr[31:5] != 27'h1fff88 || paddr[2:0] != 3'h0); endproperty
	a_err: assert property (p_err) else $error("decode error flag wrong");
	property p_rd0; !pready |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside answer");
endmodule
bind porq_sequencer porq_chk u_chk (.*);

/* tb/porq_supervisor.sv */
// Behavioural external supervisor driving the active-low reset pin.
`timescale 1ns/100ps
module porq_supervisor #(
	parameter int RESET_MS    = 200,
	parameter int MS_PER_TICK = 64
) (
	// Clock and rail status
	input  wire logic pclk,
	input  wire logic rails_ok,
	input  wire logic clk_run,
	// Reset pin
	output logic      ext_reset_n
);
	// A real reset pulse would take millions of cycles, so each clock stands for MS_PER_TICK ms.
	// The watchdog is not modelled because the block has no kick output.
	localparam int DLY = RESET_MS / MS_PER_TICK;
	int   wait_r;
	logic down_r;
	// Rail loss pulls the pin at once; the pulse length is scaled down to DLY cycles.
	always_ff @(posedge pclk or negedge rails_ok) begin
		if (!rails_ok) begin
			ext_reset_n <= 1'b0;
			down_r      <= 1'b1;
			wait_r      <= 0;
		end else if (down_r && clk_run) begin
			ext_reset_n <= 1'b0;
		end else if (wait_r < DLY) begin
			down_r      <= 1'b0;
			wait_r      <= wait_r + 1;
		end else begin
			ext_reset_n <= 1'b1;
		end
	end
endmodule

/* tb/porq_sequencer_test.sv */
// Self-checking bench for the reset sequencer and its register map.
`timescale 1ns/100ps
module porq_sequencer_test;
	localparam logic [23:0] CTRL = porq_pkg::IDX_CLOCK_RESET_CONTROL;
	logic        pclk, presetn, psel, penable, pwrite, osc_stop, rails_ok, clk_run, ext_reset_n, pll_stable;
	logic        pready, pslverr, core_reset_n, good_main_clock, aux1_run, aux2_run;
	logic        slow_clock_sel, fast_clock_sel, pll_power_down;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0]  fast_clock_prescaler, slow_clock_prescaler, aux_clock_prescaler, v, outv;
	logic [23:0] idx;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int          n_mismatch, comparisons, n;
	porq_sequencer dut (.*);
	porq_supervisor sup (.*);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [23:0] idx, input logic [7:0] d, input logic [32:0] ex);
		exp_q.push_back(ex);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {6'h0, idx, 2'h0};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [23:0] idx, input logic [7:0] ex);
		apb(1'b0, idx, 8'h0, {25'h0, ex});
	endtask
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			e = exp_q.pop_front();
			check("prdata", prdata, e[31:0]);
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
		end
	end
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (70000) @(posedge pclk);
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		{presetn, psel, penable, pwrite, rails_ok, clk_run, pll_stable, paddr, pwdata} = '0;
		osc_stop = 1'b1;
		void'($urandom(32'h13a8));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL, porq_pkg::CRC_RESET);
		apb(1'b0, 24'hfffc41, 8'h0, 33'h100000000);
		apb(1'b1, CTRL, 8'h06, 33'h0);
		apb(1'b1, CTRL, 8'h26, 33'h0);
		rd(CTRL, 8'h06);
		// Leaving the main clock is refused until the phase-locked loop is powered and locked.
		apb(1'b1, CTRL, 8'h00, 33'h0);
		rd(CTRL, 8'h02);
		pll_stable <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b1, CTRL, 8'h00, 33'h0);
		rd(CTRL, 8'h00);
		check("fclk out", {31'h0, fast_clock_sel}, 32'h0);
		check("pll off out", {31'h0, pll_power_down}, 32'h0);
		apb(1'b1, CTRL, 8'h04, 33'h0);
		rd(CTRL, 8'h00);
		apb(1'b1, CTRL, 8'h1f, 33'h0);
		rd(CTRL, 8'h1f);
		check("ctrl outs", {29'h0, slow_clock_sel, fast_clock_sel, pll_power_down}, 32'h7);
		check("aux idle", {30'h0, aux1_run, aux2_run}, 32'h0);
		for (n = 0; n < 3; n++) begin
			v   = 8'($urandom);
			idx = CTRL + 24'(2 * (n + 1));
			rd(idx, n == 0 ? porq_pkg::FAST_RESET : n == 1 ? porq_pkg::SLOW_RESET : porq_pkg::AUX_RESET);
			apb(1'b1, idx, v, 33'h0);
			apb(1'b1, idx + 24'h000001, ~v, 33'h100000000);
			rd(idx, n == 0 ? v & porq_pkg::FAST_MASK : v);
			outv = n == 0 ? fast_clock_prescaler : n == 1 ? slow_clock_prescaler : aux_clock_prescaler;
			check("prescaler out", {24'h0, outv}, {24'h0, n == 0 ? v & porq_pkg::FAST_MASK : v});
		end
		osc_stop <= 1'b0;
		rails_ok <= 1'b1;
		for (n = 0; n < 60000 && core_reset_n !== 1'b1; n++) @(posedge pclk);
		check("release time", {31'h0, n > 49000 && n < 49400}, 32'h1);
		check("good clock", {31'h0, good_main_clock}, 32'h1);
		check("aux run", {30'h0, aux1_run, aux2_run}, 32'h3);
		clk_run  <= 1'b1;
		rails_ok <= 1'b0;
		@(posedge pclk);
		check("core reset", {31'h0, core_reset_n}, 32'h0);
		rails_ok <= 1'b1;
		repeat (8) @(posedge pclk);
		check("core held", {31'h0, core_reset_n}, 32'h0);
		clk_run <= 1'b0;
		for (n = 0; n < 20 && core_reset_n !== 1'b1; n++) @(posedge pclk);
		check("rerelease", {31'h0, n > 4 && n < 12}, 32'h1);
		tally_and_finish;
	end
endmodule
